/* File: alc_pkg.sv */
// constants, field layout, timing and state codes of the level control block
// What this block does
// RULE1: normal reduce interval 104us doubling per code
// RULE2: normal raise interval 410us doubling per code
// RULE3: limiter intervals 22.7us and 90.8us, doubling
// RULE4: limits bind gain only while control enabled
// RULE5: ceiling code 111 35.25dB, minus 6dB each
// RULE6: floor code 000 -12dB, plus 6dB each
// RULE7: limiter caps gain at its starting gain
// RULE8: out-of-range gain returns to range at once
// RULE9: software starts gain between floor and ceiling
// RULE10: normal mode waits hold time before raising
// RULE11: hold expired below target, start raising
// RULE12: signal above target abandons the hold
// RULE13: sample above 87.5% reduces at fastest rate
// RULE14: peak limiter active whenever control enabled
// RULE15: gate freezes gain when level below threshold
// RULE16: gate threshold -39dB falling 6dB per code
// RULE17: gate enable bit 3, resets to 0
// RULE18: gate acts only in normal mode
// RULE19: software unmutes amplifier before enabling control
// RULE20: disabled control keeps last gain until written
// RULE21: limiter never raises above starting gain
// RULE22: intervals count samples, codes above 1010 clip
package alc_pkg;

    // register offsets
    localparam logic [6:0] ADDR_LIMITS  = 7'h20;
    localparam logic [6:0] ADDR_HOLD    = 7'h21;
    localparam logic [6:0] ADDR_RATES   = 7'h22;
    localparam logic [6:0] ADDR_GATE    = 7'h23;
    localparam logic [6:0] ADDR_STATUS  = 7'h24;

    // field positions
    localparam int EN_BIT       = 8;
    localparam int CEIL_LSB     = 3;
    localparam int FLOOR_LSB    = 0;
    localparam int HOLD_LSB     = 4;
    localparam int MODE_BIT     = 8;
    localparam int RAISE_LSB    = 4;
    localparam int REDUCE_LSB   = 0;
    localparam int GATE_EN_BIT  = 3;
    localparam int THRESH_LSB   = 0;

    // reset values
    localparam logic       EN_RST      = 1'b0;
    localparam logic       MODE_RST    = 1'b0;
    localparam logic [2:0] CEIL_RST    = 3'h7;
    localparam logic [2:0] FLOOR_RST   = 3'h0;
    localparam logic [3:0] HOLD_RST    = 4'h0;
    localparam logic [3:0] REDUCE_RST  = 4'h2;
    localparam logic [3:0] RAISE_RST   = 4'h3;
    localparam logic       GATE_EN_RST = 1'b0;
    localparam logic [2:0] THRESH_RST  = 3'h0;
    localparam logic [5:0] GAIN_RST    = 6'h10;

    // gain index: 0.75dB per step, index 0 is -12dB, 8 steps per code
    localparam logic [2:0] CEIL_FILL   = 3'h7;
    localparam logic [3:0] CODE_MAX    = 4'hA;
    localparam logic [5:0] GAIN_TOP    = 6'h3F;

    // gate: level + gain + boost (0.75dB steps) above base + step * code
    localparam int GATE_BASE    = 68;
    localparam int GATE_STEP    = 8;
    localparam int PEAK_EIGHTHS = 7;

    // timing, counted in audio samples at the reference rate
    localparam int unsigned SAMPLE_PERIOD_NS = 22676;
    localparam int unsigned ATK_NORM_NS = 104000;
    localparam int unsigned DCY_NORM_NS = 410000;
    localparam int unsigned ATK_LIM_NS  = 22700;
    localparam int unsigned DCY_LIM_NS  = 90800;
    localparam int unsigned HOLD_NS     = 2670000;
    localparam int unsigned ATK_NORM_CNT =
        (ATK_NORM_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int unsigned DCY_NORM_CNT =
        (DCY_NORM_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int unsigned ATK_LIM_CNT =
        (ATK_LIM_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int unsigned DCY_LIM_CNT =
        (DCY_LIM_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;
    localparam int unsigned HOLD_CNT =
        (HOLD_NS + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_HOLD  = 3'b010,
        ST_TRACK = 3'b100
    } alc_state_t;

endpackage : alc_pkg

/* File: step_timer.sv */
// sample-counting interval timer, one pulse per elapsed interval
`timescale 1ns/100ps
module step_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  done_q
);

    logic [CNT_W-1:0] cnt_q;

    // count sample ticks while running, restart whenever stopped
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || !run)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else if (tick)
        begin
            if ({1'b0, cnt_q} + 1'b1 >= {1'b0, limit})
            begin
                cnt_q  <= '0;
                done_q <= 1'b1;
            end
            else
            begin
                cnt_q  <= cnt_q + 1'b1;
                done_q <= 1'b0;
            end
        end
        else
        begin
            done_q <= 1'b0;
        end
    end

endmodule : step_timer

/* File: level_judge.sv */
// peak detector and quiet gate comparator on the record samples
`timescale 1ns/100ps
module level_judge
    import alc_pkg::*;
#(
    parameter int ADC_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic [ADC_W-1:0] adc_mag,
    input  wire logic [7:0]       level_steps,
    input  wire logic [5:0]       gain,
    input  wire logic [5:0]       boost_steps,
    input  wire logic [2:0]       thresh,
    output logic                  peak_q,
    output logic                  quiet_q
);

    localparam logic [ADC_W-1:0] PEAK_LIM = ADC_W'(PEAK_EIGHTHS) << (ADC_W - 3);

    logic [9:0] sum;
    logic [9:0] gate_lim;

    // level below threshold referred to the input pins
    assign sum      = 10'(level_steps) + 10'(gain) + 10'(boost_steps);
    assign gate_lim = 10'(GATE_BASE) + 10'(GATE_STEP) * 10'(thresh); // RULE16

    // registered judgements
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            peak_q  <= 1'b0;
            quiet_q <= 1'b0;
        end
        else
        begin
            peak_q  <= adc_mag > PEAK_LIM; // RULE13
            quiet_q <= sum > gate_lim;     // RULE15
        end
    end

endmodule : level_judge

/* File: alc_gain_controller.sv */
// automatic level control of the record amplifier gain
`timescale 1ns/100ps
module alc_gain_controller
    import alc_pkg::*;
#(
    parameter int ADC_W = 16,
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             reg_we,
    input  wire logic [6:0]       reg_addr,
    input  wire logic [8:0]       reg_wdata,
    output logic      [8:0]       reg_rdata_q,
    input  wire logic             vol_we,
    input  wire logic [5:0]       vol_gain,
    input  wire logic             sample_tick,
    input  wire logic             above_target,
    input  wire logic [ADC_W-1:0] adc_mag,
    input  wire logic [7:0]       level_steps,
    input  wire logic [5:0]       boost_steps,
    output logic      [5:0]       amp_gain_q
);

    // configuration
    logic       en_q;
    logic       mode_q;
    logic [2:0] ceil_code_q;
    logic [2:0] floor_code_q;
    logic [3:0] hold_code_q;
    logic [3:0] atk_q;
    logic [3:0] dcy_q;
    logic       gate_en_q;
    logic [2:0] thresh_q;

    // control state
    alc_state_t state_q;
    logic       above_prev_q;
    logic       mode_prev_q;
    logic [5:0] start_q;
    logic [5:0] gain_d;

    // derived
    logic             run;
    logic             capture;
    logic [5:0]       start_live;
    logic [5:0]       ceil_idx;
    logic [5:0]       floor_idx;
    logic [5:0]       ceil_eff;
    logic             peak;
    logic             quiet;
    logic             gated;
    logic             red_run;
    logic             rse_run;
    logic             red_done;
    logic             rse_done;
    logic             hold_done;
    logic [CNT_W-1:0] red_lim;
    logic [CNT_W-1:0] rse_lim;
    logic [CNT_W-1:0] hold_lim;
    logic [3:0]       hold_c;

    // interval for a rate code, doubling per code, clipped at the top code
    function automatic logic [CNT_W-1:0] step_len(input int unsigned base,
                                                  input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code; // RULE22
        step_len = CNT_W'(base << c);
    endfunction : step_len

    // register writes
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            en_q         <= EN_RST;
            mode_q       <= MODE_RST;
            ceil_code_q  <= CEIL_RST;
            floor_code_q <= FLOOR_RST;
            hold_code_q  <= HOLD_RST;
            atk_q        <= REDUCE_RST;
            dcy_q        <= RAISE_RST;
            gate_en_q    <= GATE_EN_RST; // RULE17
            thresh_q     <= THRESH_RST;
        end
        else if (reg_we)
        begin
            unique case (reg_addr)
                ADDR_LIMITS:
                begin
                    en_q         <= reg_wdata[EN_BIT];
                    ceil_code_q  <= reg_wdata[CEIL_LSB +: 3];
                    floor_code_q <= reg_wdata[FLOOR_LSB +: 3];
                end
                ADDR_HOLD:  hold_code_q <= reg_wdata[HOLD_LSB +: 4];
                ADDR_RATES:
                begin
                    mode_q <= reg_wdata[MODE_BIT];
                    dcy_q  <= reg_wdata[RAISE_LSB +: 4];
                    atk_q  <= reg_wdata[REDUCE_LSB +: 4];
                end
                ADDR_GATE:
                begin
                    gate_en_q <= reg_wdata[GATE_EN_BIT]; // RULE17
                    thresh_q  <= reg_wdata[THRESH_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // registered readback, unmapped and reserved bits read zero
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            reg_rdata_q <= 9'h000;
        else
        begin
            reg_rdata_q <= 9'h000;
            unique case (reg_addr)
                ADDR_LIMITS: reg_rdata_q <= {en_q, 2'h0, ceil_code_q, floor_code_q};
                ADDR_HOLD:   reg_rdata_q <= {1'b0, hold_code_q, 4'h0};
                ADDR_RATES:  reg_rdata_q <= {mode_q, dcy_q, atk_q};
                ADDR_GATE:   reg_rdata_q <= {5'h00, gate_en_q, thresh_q};
                ADDR_STATUS: reg_rdata_q <= {(state_q == ST_HOLD), gated, 1'b0, amp_gain_q};
                default:     reg_rdata_q <= 9'h000;
            endcase
        end
    end

    // peak and quiet detection
    level_judge #(
        .ADC_W (ADC_W)
    ) u_judge (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .adc_mag     (adc_mag),
        .level_steps (level_steps),
        .gain        (amp_gain_q),
        .boost_steps (boost_steps),
        .thresh      (thresh_q),
        .peak_q      (peak),
        .quiet_q     (quiet)
    );

    // gain limits as gain indices
    assign ceil_idx  = {ceil_code_q, CEIL_FILL};  // RULE5
    assign floor_idx = {floor_code_q, 3'h0};      // RULE6

    // limiter start gain, taken at enable or at switchover
    assign run        = (state_q != ST_OFF);
    assign capture    = mode_q && ((!run && en_q) || (run && !mode_prev_q)); // RULE21
    assign start_live = capture ? amp_gain_q : start_q;
    assign ceil_eff   = (mode_q && start_live < ceil_idx) ? start_live : ceil_idx; // RULE7

    // gate acts in normal mode only
    assign gated = run && !mode_q && gate_en_q && quiet; // RULE15 RULE18

    // reduce on peak or above target, peak limiter always on while running
    assign red_run = run && (peak || above_target); // RULE14
    assign rse_run = run && (state_q == ST_TRACK) && !peak && !above_target && !gated;

    // step intervals per mode and code
    always_comb
    begin
        if (peak)
            red_lim = step_len(mode_q ? ATK_LIM_CNT : ATK_NORM_CNT, 4'h0); // RULE13
        else if (mode_q)
            red_lim = step_len(ATK_LIM_CNT, atk_q);  // RULE3
        else
            red_lim = step_len(ATK_NORM_CNT, atk_q); // RULE1
        rse_lim = mode_q ? step_len(DCY_LIM_CNT, dcy_q)   // RULE3
                         : step_len(DCY_NORM_CNT, dcy_q); // RULE2
    end

    // hold time: code 0 has none, code n is base doubled n-1 times
    assign hold_c   = (hold_code_q > CODE_MAX) ? CODE_MAX : hold_code_q; // RULE22
    assign hold_lim = CNT_W'(HOLD_CNT << (hold_c - 4'h1)); // RULE10

    step_timer #(.CNT_W(CNT_W)) u_reduce (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .run     (red_run),
        .tick    (sample_tick),
        .limit   (red_lim),
        .done_q  (red_done)
    );

    step_timer #(.CNT_W(CNT_W)) u_raise (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .run     (rse_run),
        .tick    (sample_tick),
        .limit   (rse_lim),
        .done_q  (rse_done)
    );

    step_timer #(.CNT_W(CNT_W)) u_hold (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .run     (state_q == ST_HOLD),
        .tick    (sample_tick),
        .limit   (hold_lim),
        .done_q  (hold_done)
    );

    // control state machine
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            state_q <= ST_OFF;
        else
        begin
            unique case (state_q)
                ST_OFF:
                    if (en_q)
                        state_q <= ST_TRACK;
                ST_TRACK:
                    if (!en_q)
                        state_q <= ST_OFF;
                    else if (!mode_q && hold_c != 4'h0 && above_prev_q && !above_target)
                        state_q <= ST_HOLD; // RULE10
                ST_HOLD:
                    if (!en_q)
                        state_q <= ST_OFF;
                    else if (mode_q || above_target)
                        state_q <= ST_TRACK; // RULE12
                    else if (hold_done)
                        state_q <= ST_TRACK; // RULE11
                default:
                    state_q <= ST_OFF;
            endcase
        end
    end

    // history flags and limiter start gain
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            above_prev_q <= 1'b0;
            mode_prev_q  <= MODE_RST;
            start_q      <= GAIN_RST;
        end
        else
        begin
            above_prev_q <= above_target || peak;
            mode_prev_q  <= mode_q;
            start_q      <= start_live; // RULE21
        end
    end

    // next gain: one step per interval, then clamp into range
    always_comb
    begin
        gain_d = amp_gain_q;
        if (red_done && amp_gain_q != 6'h00)
            gain_d = amp_gain_q - 6'h01;
        else if (rse_done && rse_run && amp_gain_q != GAIN_TOP)
            gain_d = amp_gain_q + 6'h01;
        if (gain_d < floor_idx)
            gain_d = floor_idx; // RULE8
        if (gain_d > ceil_eff)
            gain_d = ceil_eff;  // RULE8
    end

    // amplifier gain register: volume writes only while control is off
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            amp_gain_q <= GAIN_RST;
        else if (run)
            amp_gain_q <= gain_d; // RULE4
        else if (vol_we)
            amp_gain_q <= vol_gain; // RULE20
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_drop;
        state_q == ST_TRACK && en_q && !mode_q && hold_c != 4'h0
            && above_prev_q && !above_target;
    endsequence

    sequence s_hold_expire;
        state_q == ST_HOLD && en_q && !mode_q && !above_target && hold_done;
    endsequence

    a_off_gain_kept: assert property ( // RULE20
        !run && !vol_we |=> $stable(amp_gain_q))
        else $error("gain moved while level control off");

    a_range_held: assert property ( // RULE8
        $past(run) && $past(ceil_eff) >= $past(floor_idx)
            |-> amp_gain_q <= $past(ceil_eff) && amp_gain_q >= $past(floor_idx))
        else $error("gain left floor to ceiling range");

    a_ceiling_decode: assert property ( // RULE5
        ceil_code_q == 3'h0 |-> ceil_idx == 6'h07)
        else $error("ceiling code 0 not -6.75 dB");

    a_floor_decode: assert property ( // RULE6
        floor_code_q == 3'h7 |-> floor_idx == 6'h38)
        else $error("floor code 7 not 30 dB");

    a_limiter_cap: assert property ( // RULE7
        $past(run) && $past(mode_q) |-> amp_gain_q <= $past(start_live))
        else $error("limiter gain above starting gain");

    a_hold_entry: assert property ( // RULE10
        s_drop |=> state_q == ST_HOLD)
        else $error("hold not entered after level drop");

    a_hold_expire: assert property ( // RULE11
        s_hold_expire |=> state_q == ST_TRACK ##1 rse_run || above_target || peak
            || gated || !en_q)
        else $error("raise not resumed after hold");

    a_hold_abandon: assert property ( // RULE12
        state_q == ST_HOLD && en_q && above_target |=> state_q == ST_TRACK)
        else $error("hold not abandoned on loud signal");

    a_no_hold_limiter: assert property ( // RULE10
        mode_q && $past(mode_q) && $past(state_q) != ST_HOLD |-> state_q != ST_HOLD)
        else $error("hold entered in limiter mode");

    a_peak_rate: assert property ( // RULE13
        run && peak |-> red_run
            && red_lim == CNT_W'(mode_q ? ATK_LIM_CNT : ATK_NORM_CNT))
        else $error("peak not reduced at fastest rate");

    a_norm_reduce: assert property ( // RULE1
        red_run && !peak && !mode_q && atk_q == 4'h1 |-> red_lim == CNT_W'(ATK_NORM_CNT * 2))
        else $error("normal reduce interval wrong");

    a_norm_raise: assert property ( // RULE2
        !mode_q && dcy_q == 4'h0 |-> rse_lim == CNT_W'(DCY_NORM_CNT))
        else $error("normal raise interval wrong");

    a_code_clip: assert property ( // RULE22
        mode_q && dcy_q > CODE_MAX |-> rse_lim == CNT_W'(DCY_LIM_CNT << 10))
        else $error("rate code above top not clipped");

    a_gate_freeze: assert property ( // RULE15
        gated |-> !rse_run)
        else $error("gain raised while gate closed");

    a_gate_normal: assert property ( // RULE18
        mode_q |-> !gated)
        else $error("gate active in limiter mode");

    a_gate_reset: assert property ( // RULE17
        $past(!rst_b) |-> !gate_en_q)
        else $error("gate enable not clear after reset");

endmodule : alc_gain_controller

/* File: rec_path_model.sv */
// record path model: sample ticks and level flags from a source setting
`timescale 1ns/100ps
module rec_path_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  src_mode,
    output logic             sample_tick,
    output logic             above_target,
    output logic [15:0]      adc_mag,
    output logic [7:0]       level_steps
);
    // one sample per clock keeps every interval short
    always_ff @(posedge ref_clk)
    begin
        sample_tick <= rst_b;
    end

    // 0 quiet, 1 below target, 2 above target, 3 near clipping
    always_comb
    begin
        above_target = src_mode[1];
        adc_mag      = (src_mode == 2'h3) ? 16'hF000 : 16'h1000;
        level_steps  = (src_mode == 2'h0) ? 8'hC8 : 8'h00;
    end
endmodule : rec_path_model

/* File: tb.sv */
// self-checking bench for the record gain level control
`timescale 1ns/100ps
module tb;
    import alc_pkg::*;
    logic        ref_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic        reg_we    = 1'b0;
    logic [6:0]  reg_addr  = 7'h00;
    logic [8:0]  reg_wdata = 9'h000;
    logic        vol_we    = 1'b0;
    logic [5:0]  vol_gain  = 6'h00;
    logic [1:0]  src_mode  = 2'h1;
    logic        sample_tick;
    logic        above_target;
    logic [15:0] adc_mag;
    logic [7:0]  level_steps;
    logic [8:0]  reg_rdata_q;
    logic [5:0]  amp_gain_q;
    logic [5:0]  g;
    int          n_fail  = 0;
    int          checked = 0;
    int          n;

    always #50 ref_clk = ~ref_clk;

    rec_path_model u_path (.ref_clk(ref_clk), .rst_b(rst_b), .src_mode(src_mode),
        .sample_tick(sample_tick), .above_target(above_target), .adc_mag(adc_mag),
        .level_steps(level_steps));

    alc_gain_controller u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .vol_we(vol_we), .vol_gain(vol_gain), .sample_tick(sample_tick),
        .above_target(above_target), .adc_mag(adc_mag), .level_steps(level_steps),
        .boost_steps(6'h00), .amp_gain_q(amp_gain_q));

    task final_report;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // let k edges pass and step past their updates
    task cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : cyc

    task wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge ref_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask : wr

    // readback lands one cycle after the address is taken
    task rd(input logic [6:0] a, input logic [8:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        cyc(1);
        chk("readback", {7'h00, reg_rdata_q}, {7'h00, exp});
    endtask : rd

    task vol(input logic [5:0] v);
        @(posedge ref_clk);
        vol_we   <= 1'b1;
        vol_gain <= v;
        @(posedge ref_clk);
        vol_we <= 1'b0;
        #1;
    endtask : vol

    task src(input logic [1:0] m);
        @(posedge ref_clk);
        src_mode <= m;
    endtask : src

    task wait_chg(input int lim, output int i);
        logic [5:0] s;
        s = amp_gain_q;
        i = 0;
        while (amp_gain_q === s && i < lim)
        begin
            cyc(1);
            i++;
        end
    endtask : wait_chg

    // cycles between two gain steps, after syncing to a step
    task gap(input int lim, output int k);
        int d;
        wait_chg(lim, d);
        wait_chg(lim, d);
        wait_chg(lim, k);
    endtask : gap

    task t_reset;
        chk("reset gain", {10'h0, amp_gain_q}, {10'h0, GAIN_RST});
        rd(ADDR_LIMITS, 9'h038);
        rd(ADDR_HOLD, 9'h000);
        rd(ADDR_RATES, 9'h032);
        rd(ADDR_GATE, 9'h000);
        rd(7'h30, 9'h000);
    endtask : t_reset

    task t_limits;
        wr(ADDR_LIMITS, 9'h03F);
        vol(6'h00);
        cyc(5);
        chk("gain off", {10'h0, amp_gain_q}, 16'h0000);
        rd(ADDR_LIMITS, 9'h03F);
        wr(ADDR_LIMITS, 9'h13A);
        cyc(3);
        chk("floor clamp", {10'h0, amp_gain_q}, 16'h0010);
        wr(ADDR_LIMITS, 9'h102);
        cyc(3);
        chk("ceil clamp", {10'h0, amp_gain_q}, 16'h0007);
    endtask : t_limits

    task t_rates;
        wr(ADDR_LIMITS, 9'h138);
        wr(ADDR_RATES, 9'h000);
        gap(100, n);
        chk("raise gap", 16'(n), 16'd19);
        cyc(1300);
        chk("top gain", {10'h0, amp_gain_q}, 16'h003F);
        src(2'h2);
        gap(100, n);
        chk("reduce gap", 16'(n), 16'd5);
        wr(ADDR_RATES, 9'h001);
        gap(100, n);
        chk("reduce gap1", 16'(n), 16'd10);
        wr(ADDR_RATES, 9'h005);
        src(2'h3);
        gap(400, n);
        chk("peak gap", 16'(n), 16'd5);
        src(2'h2);
        wr(ADDR_RATES, 9'h00B);
        gap(6000, n);
        chk("clip gap", 16'(n), 16'd5120);
    endtask : t_rates

    task t_hold;
        wr(ADDR_RATES, 9'h000);
        wr(ADDR_HOLD, 9'h010);
        cyc(20);
        src(2'h1);
        // let a reduce step already in flight land before sampling the gain
        cyc(2);
        g = amp_gain_q;
        cyc(108);
        chk("in hold", {10'h0, amp_gain_q}, {10'h0, g});
        rd(ADDR_STATUS, {3'b100, g});
        cyc(40);
        chk("after hold", {15'h0, amp_gain_q > g}, 16'h0001);
        src(2'h2);
        src(2'h1);
        cyc(50);
        g = amp_gain_q;
        src(2'h2);
        cyc(20);
        chk("hold abort", {15'h0, amp_gain_q < g}, 16'h0001);
    endtask : t_hold

    task t_gate;
        wr(ADDR_HOLD, 9'h000);
        wr(ADDR_GATE, 9'h00F);
        src(2'h0);
        cyc(3);
        g = amp_gain_q;
        cyc(100);
        chk("gate frozen", {10'h0, amp_gain_q}, {10'h0, g});
        rd(ADDR_STATUS, {3'b010, g});
        wr(ADDR_GATE, 9'h007);
        cyc(60);
        chk("gate open", {15'h0, amp_gain_q > g}, 16'h0001);
    endtask : t_gate

    task t_limiter;
        wr(ADDR_LIMITS, 9'h038);
        vol(6'h20);
        wr(ADDR_RATES, 9'h100);
        src(2'h2);
        wr(ADDR_LIMITS, 9'h138);
        cyc(20);
        gap(50, n);
        chk("lim reduce", 16'(n), 16'd2);
        wr(ADDR_GATE, 9'h00F);
        src(2'h0);
        gap(50, n);
        chk("lim raise", 16'(n), 16'd5);
        cyc(200);
        chk("lim cap", {10'h0, amp_gain_q}, 16'h0020);
    endtask : t_limiter

    task t_disable;
        src(2'h2);
        cyc(7);
        wr(ADDR_LIMITS, 9'h038);
        cyc(2);
        g = amp_gain_q;
        cyc(50);
        chk("kept gain", {10'h0, amp_gain_q}, {10'h0, g});
        vol(6'h05);
        cyc(1);
        chk("new volume", {10'h0, amp_gain_q}, 16'h0005);
        rd(ADDR_STATUS, 9'h005);
    endtask : t_disable

    // main sequence: reset, then every scenario in turn
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(2);
        t_reset();
        t_limits();
        t_rates();
        t_hold();
        t_gate();
        t_limiter();
        t_disable();
        final_report();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #6000000;
        n_fail++;
        final_report();
    end
endmodule : tb
